// >>> core/wan_port.v
// WAN nibble port in PHY role plus per-port link strap decoding.
// Assumes straps settle before reset release; partner MAC samples on rising clock.
//
// Functional notes
// - Transmit nibble is sampled on each rising edge of the WAN transmit clock.
// - Nibbles are accepted only while the sampled transmit enable is high.
// - Collision output high only in half duplex, during a collision or while the collision test bit is set.
// - Receive valid frames each received nibble, launched on the receive clock fall.
// - Receive nibble changes only on falling edges of the receive clock.
// - High force strap disables autonegotiation; low advertises every capability.
// - With external select high and LAN role strap low (PHY role), port four straps steer the LAN interface link.
// - Force straps come from alternate pins while the LAN interface is MAC role.
// - High speed strap forces 100 Mb/s; low forces 10 Mb/s.
// - High duplex strap forces full duplex; low forces half duplex.
// - With external select high and LAN role strap low (PHY role), port four speed and duplex apply to the LAN link.
// - LAN role strap high selects MAC role, low selects PHY role.
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`include "wan_port_consts.vh"
module wan_port #(
  parameter NPORTS = 5
) (
  // System
  input  wire              clk_i,
  input  wire              rst_i,
  // Wishbone slave
  input  wire              cyc_i,
  input  wire              stb_i,
  input  wire              we_i,
  input  wire [3:0]        adr_i,
  input  wire [3:0]        sel_i,
  input  wire [31:0]       dat_i,
  output reg  [31:0]       dat_o,
  output reg               ack_o,
  // Strap pins
  input  wire [NPORTS-1:0] force_strap_i,
  input  wire [NPORTS-1:0] force_alt_strap_i,
  input  wire [NPORTS-1:0] speed_strap_i,
  input  wire [NPORTS-1:0] duplex_strap_i,
  input  wire              external_port_select_strap_i,
  input  wire              lan_if_mac_role_strap_i,
  // Decoded link settings
  output reg  [NPORTS-1:0] autonegotiation_o,
  output reg  [NPORTS-1:0] forced_100_o,
  output reg  [NPORTS-1:0] forced_full_o,
  output reg               lan_phy_forced_o,
  output reg               lan_phy_100_o,
  output reg               lan_phy_full_o,
  output reg               lan_mac_role_o,
  // WAN nibble pins toward the external MAC
  output reg               wan_tx_clock_o,
  output reg               wan_rx_clock_o,
  input  wire [3:0]        wan_tx_nibble_i,
  input  wire              wan_tx_enable_i,
  output reg  [3:0]        wan_rx_nibble_o,
  output reg               wan_rx_valid_o,
  output reg               wan_collision_o,
  // Switch side of port four
  output reg  [3:0]        sw_rx_nibble_o,
  output reg               sw_rx_sof_o,
  output reg               sw_rx_valid_o,
  input  wire              sw_rx_ready_i,
  input  wire [3:0]        sw_tx_nibble_i,
  input  wire              sw_tx_valid_i,
  output reg               sw_tx_ready_o,
  input  wire              sw_collision_i
);
  localparam integer HALF_FAST = (`SYS_CLK_HZ / `FAST_MII_HZ) / 2;
  localparam integer HALF_SLOW = (`SYS_CLK_HZ / `SLOW_MII_HZ) / 2;
  localparam [4:0]   DIV_FAST  = HALF_FAST[4:0];
  localparam [4:0]   DIV_SLOW  = HALF_SLOW[4:0];
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_FRAME = 3'b010;
  localparam [2:0] ST_GAP   = 3'b100;

  // Captured straps
  reg [NPORTS-1:0] cap_force;
  reg [NPORTS-1:0] cap_speed;
  reg [NPORTS-1:0] cap_duplex;
  reg              cap_ext;
  reg              cap_mac;
  // Strap pin synchronisers
  reg [4*NPORTS+1:0] strap_s1;
  reg [4*NPORTS+1:0] strap_s2;
  // Software control
  reg              link_en;
  reg              coll_test;
  // Clock divider
  reg [4:0]        div_cnt;
  reg              mii_clk;
  wire             port4_100;
  // Transmit path
  reg [3:0]        txd_s1;
  reg [3:0]        txd_s2;
  reg              txen_s1;
  reg              txen_s2;
  reg [2:0]        tx_state;
  reg              tx_first;
  wire             tx_rise;
  wire             buf_in_ready;
  wire [4:0]       buf_out_data;
  wire             buf_out_valid;
  wire             buf_out_ready;
  // Receive path
  reg              rx_active;
  wire             rx_fall;
  wire             port4_full;
  reg [31:0]       next_dat;
  reg              bad_combo;

  assign port4_100  = cap_speed[NPORTS-1] | ~cap_force[NPORTS-1];
  assign port4_full = cap_duplex[NPORTS-1] | ~cap_force[NPORTS-1];
  assign tx_rise    = (div_cnt == 5'h00) && !mii_clk;
  assign rx_fall    = wan_rx_clock_o && !mii_clk;

  // Illegal strap combination detector
  function combo_bad;
    input f;
    input s;
    input d;
    begin
      combo_bad = f & ~s & ~d;
    end
  endfunction

  // Strap capture while reset is asserted, after two synchroniser stages
  always @(posedge clk_i)
  begin
    strap_s1 <= {lan_if_mac_role_strap_i, external_port_select_strap_i, duplex_strap_i,
                 speed_strap_i, force_alt_strap_i, force_strap_i};
    strap_s2 <= strap_s1;
    if (rst_i)
    begin
      cap_force  <= strap_s2[4*NPORTS+1] ? strap_s2[2*NPORTS-1:NPORTS]
                                         : strap_s2[NPORTS-1:0];
      cap_speed  <= strap_s2[3*NPORTS-1:2*NPORTS];
      cap_duplex <= strap_s2[4*NPORTS-1:3*NPORTS];
      cap_ext    <= strap_s2[4*NPORTS];
      cap_mac    <= strap_s2[4*NPORTS+1];
    end
  end

  // Decoded settings
  integer i;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      autonegotiation_o <= {NPORTS{1'b1}};
      forced_100_o      <= {NPORTS{1'b0}};
      forced_full_o     <= {NPORTS{1'b0}};
      lan_phy_forced_o  <= 1'b0;
      lan_phy_100_o     <= 1'b0;
      lan_phy_full_o    <= 1'b0;
      lan_mac_role_o    <= 1'b0;
      bad_combo         <= 1'b0;
    end
    else
    begin
      autonegotiation_o <= ~cap_force;
      forced_100_o      <= cap_force & cap_speed;
      forced_full_o     <= cap_force & cap_duplex;
      lan_phy_forced_o  <= cap_ext & ~cap_mac & cap_force[NPORTS-1];
      lan_phy_100_o     <= cap_ext & ~cap_mac & cap_speed[NPORTS-1];
      lan_phy_full_o    <= cap_ext & ~cap_mac & cap_duplex[NPORTS-1];
      lan_mac_role_o    <= cap_mac;
      bad_combo         <= 1'b0;
      for (i = 0; i < NPORTS; i = i + 1)
        if (combo_bad(cap_force[i], cap_speed[i], cap_duplex[i]))
          bad_combo <= 1'b1;
    end
  end

  // WAN clock generation, 25 MHz or 2.5 MHz
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_cnt        <= 5'h00;
      mii_clk        <= 1'b0;
      wan_tx_clock_o <= 1'b0;
      wan_rx_clock_o <= 1'b0;
    end
    else
    begin
      if (div_cnt == 5'h00)
      begin
        div_cnt <= (port4_100 ? DIV_FAST : DIV_SLOW) - 5'h01;
        mii_clk <= ~mii_clk;
      end
      else
        div_cnt <= div_cnt - 5'h01;
      wan_tx_clock_o <= mii_clk;
      wan_rx_clock_o <= mii_clk;
    end
  end

  // Pin synchronisers for transmit inputs
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      txd_s1  <= 4'h0;
      txd_s2  <= 4'h0;
      txen_s1 <= 1'b0;
      txen_s2 <= 1'b0;
    end
    else
    begin
      txd_s1  <= wan_tx_nibble_i;
      txd_s2  <= txd_s1;
      txen_s1 <= wan_tx_enable_i;
      txen_s2 <= txen_s1;
    end
  end

  // Transmit framing, sampled on pin clock rising edge
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_state <= ST_IDLE;
      tx_first <= 1'b0;
    end
    else if (tx_rise)
    begin
      case (tx_state)
        ST_IDLE:
          if (txen_s2 && link_en)
          begin
            tx_state <= ST_FRAME;
            tx_first <= !buf_in_ready;
          end
        ST_FRAME:
        begin
          if (buf_in_ready)
            tx_first <= 1'b0;
          if (!txen_s2)
            tx_state <= ST_GAP;
        end
        ST_GAP:
          tx_state <= ST_IDLE;
        default:
          tx_state <= ST_IDLE;
      endcase
    end
  end

  nibble_skid #(
    .W (5)
  ) u_skid (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   ({tx_first | (tx_state == ST_IDLE), txd_s2}),
    .in_valid_i  (tx_rise && txen_s2 && (tx_state == ST_FRAME ||
                  (tx_state == ST_IDLE && link_en))),
    .in_ready_o  (buf_in_ready),
    .out_data_o  (buf_out_data),
    .out_valid_o (buf_out_valid),
    .out_ready_i (buf_out_ready)
  );

  assign buf_out_ready = !sw_rx_valid_o || sw_rx_ready_i;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sw_rx_valid_o  <= 1'b0;
      sw_rx_nibble_o <= 4'h0;
      sw_rx_sof_o    <= 1'b0;
    end
    else if (buf_out_ready)
    begin
      sw_rx_valid_o  <= buf_out_valid;
      sw_rx_nibble_o <= buf_out_data[3:0];
      sw_rx_sof_o    <= buf_out_data[4];
    end
  end

  // Receive path toward the MAC, launched on falling pin edge
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wan_rx_nibble_o <= 4'h0;
      wan_rx_valid_o  <= 1'b0;
      sw_tx_ready_o   <= 1'b0;
      rx_active       <= 1'b0;
    end
    else
    begin
      sw_tx_ready_o <= rx_fall && link_en && sw_tx_valid_i;
      if (rx_fall)
      begin
        wan_rx_valid_o  <= sw_tx_valid_i && link_en;
        rx_active       <= sw_tx_valid_i && link_en;
        wan_rx_nibble_o <= sw_tx_valid_i ? sw_tx_nibble_i : 4'h0;
      end
    end
  end

  // Collision only in half duplex
  always @(posedge clk_i)
  begin
    if (rst_i)
      wan_collision_o <= 1'b0;
    else
      wan_collision_o <= !port4_full && (sw_collision_i || coll_test) && link_en;
  end

  // Wishbone register access
  always @*
  begin
    next_dat = 32'h00000000;
    case (adr_i)
      `REG_CTRL:
      begin
        next_dat[`CTRL_LINK_EN]   = link_en;
        next_dat[`CTRL_COLL_TEST] = coll_test;
      end
      `REG_STRAP:
        next_dat[4*NPORTS+1-NPORTS:0] = {cap_mac, cap_ext, cap_duplex, cap_speed, cap_force};
      `REG_PORT_CFG:
        next_dat[14:0] = {forced_full_o, forced_100_o, autonegotiation_o};
      `REG_STATUS:
      begin
        next_dat[`STAT_TX_READY]  = buf_in_ready;
        next_dat[`STAT_RX_ACTIVE] = rx_active;
        next_dat[`STAT_TX_FRAME]  = (tx_state == ST_FRAME);
        next_dat[`STAT_BAD_COMBO] = bad_combo;
      end
      default:
        next_dat = 32'h00000000;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o     <= 1'b0;
      dat_o     <= 32'h00000000;
      link_en   <= 1'b1;
      coll_test <= 1'b0;
    end
    else
    begin
      ack_o <= cyc_i && stb_i && !ack_o;
      dat_o <= next_dat;
      if (cyc_i && stb_i && ack_o && we_i && sel_i[0] && adr_i == `REG_CTRL)
      begin
        link_en   <= dat_i[`CTRL_LINK_EN];
        coll_test <= dat_i[`CTRL_COLL_TEST];
      end
    end
  end
endmodule // wan_port

// >>> inc/wan_port_consts.vh
// Constants for the WAN nibble port and link strap block.
// Included by the WAN port core file; holds definitions only.
`ifndef WAN_PORT_CONSTS_VH
`define WAN_PORT_CONSTS_VH

// Register byte offsets
`define REG_CTRL        4'h0
`define REG_STRAP       4'h4
`define REG_PORT_CFG    4'h8
`define REG_STATUS      4'hc

// Control register fields
`define CTRL_LINK_EN    0
`define CTRL_COLL_TEST  1

// Status register fields
`define STAT_TX_READY   0
`define STAT_RX_ACTIVE  1
`define STAT_TX_FRAME   2
`define STAT_BAD_COMBO  3

// Clock rates
`define SYS_CLK_HZ      50000000
`define FAST_MII_HZ     25000000
`define SLOW_MII_HZ     2500000

// Strap defaults after reset
`define STRAP_RESET     16'h0000

`endif

// >>> core/nibble_skid.v
// Two-entry buffer for nibble words with valid and ready on both sides.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/100ps
module nibble_skid #(
  parameter W = 5
) (
  // System
  input  wire         clk_i,
  input  wire         rst_i,
  // Fill side
  input  wire [W-1:0] in_data_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  // Drain side
  output wire [W-1:0] out_data_o,
  output wire         out_valid_o,
  input  wire         out_ready_i
);
  reg [W-1:0] mem [0:1];
  reg         wr_ptr;
  reg         rd_ptr;
  reg [1:0]   count;
  wire        push;
  wire        pop;

  assign in_ready_o  = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push && !pop)
        count <= count + 2'h1;
      else if (pop && !push)
        count <= count - 2'h1;
    end
  end
endmodule // nibble_skid

// >>> tb/wan_port_assertions.sv
// Concurrent checks for the WAN port block, seeing its top ports only.
// Assumes a bind from the bench top that hands NPORTS on.
`timescale 1ns/100ps
module wan_port_assertions #(
  parameter NPORTS = 5
) (
  // System and bus
  input wire              clk_i,
  input wire              rst_i,
  input wire              cyc_i,
  input wire              stb_i,
  input wire              ack_o,
  // Decoded straps
  input wire [NPORTS-1:0] autonegotiation_o,
  input wire [NPORTS-1:0] forced_100_o,
  input wire [NPORTS-1:0] forced_full_o,
  input wire              lan_phy_forced_o,
  input wire              lan_mac_role_o,
  // Nibble pins
  input wire              wan_tx_clock_o,
  input wire              wan_rx_clock_o,
  input wire [3:0]        wan_rx_nibble_o,
  input wire              wan_rx_valid_o,
  input wire              wan_collision_o,
  input wire              sw_collision_i
);
  reg  [3:0] up;
  reg  [3:0] run;
  wire       fast = autonegotiation_o[4] | forced_100_o[4];
  wire       half = !autonegotiation_o[4] & !forced_full_o[4];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Cycles since reset, and since the last link clock edge
  always @(posedge clk_i)
  begin
    up <= rst_i ? 4'h0 : up + {3'h0, up != 4'hf};
    run <= (rst_i || $changed(wan_tx_clock_o)) ? 4'h0 : run + 4'h1;
  end
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_coll_half; wan_collision_o |-> half; endproperty
  a_coll_half: assert property (p_coll_half) else $error("collision out of half");
  property p_coll_cause; (half && sw_collision_i) [*3] |-> wan_collision_o; endproperty
  a_coll_cause: assert property (p_coll_cause) else $error("collision lost");
  property p_held;
    !$past(rst_i) && !$past(rst_i, 2) |-> $stable({autonegotiation_o, forced_100_o,
      forced_full_o, lan_phy_forced_o, lan_mac_role_o});
  endproperty
  a_held: assert property (p_held) else $error("strap result moved");
  property p_same_clk; wan_tx_clock_o == wan_rx_clock_o; endproperty
  a_same_clk: assert property (p_same_clk) else $error("link clocks differ");
  property p_fast; up == 4'hf && fast |-> $changed(wan_tx_clock_o); endproperty
  a_fast: assert property (p_fast) else $error("fast clock stalled");
  property p_slow;
    up == 4'hf && !fast |-> run < 4'ha && (!$changed(wan_tx_clock_o) || run == 4'h9);
  endproperty
  a_slow: assert property (p_slow) else $error("slow clock spacing");
  property p_rx_fall;
    $changed({wan_rx_nibble_o, wan_rx_valid_o}) |-> $fell(wan_rx_clock_o);
  endproperty
  a_rx_fall: assert property (p_rx_fall) else $error("rx moved off fall");
  property p_phy_role; lan_phy_forced_o |-> !lan_mac_role_o && !autonegotiation_o[4]; endproperty
  a_phy_role: assert property (p_phy_role) else $error("lan force wrong");
  c_ack: cover property (ack_o);
  c_coll: cover property (wan_collision_o);
  c_rx: cover property ($rose(wan_rx_valid_o));
endmodule // wan_port_assertions

// >>> tb/wan_mac_model.sv
// External MAC model on the WAN nibble pins.
// Assumes the block drives both link clocks; a frame starts on go_i.
`timescale 1ns/100ps
module wan_mac_model (
  // Nibble pins
  input  wire       wan_tx_clock_i,
  input  wire       wan_rx_clock_i,
  input  wire [3:0] wan_rx_nibble_i,
  input  wire       wan_rx_valid_i,
  output reg  [3:0] wan_tx_nibble_o = 4'h0,
  output reg        wan_tx_enable_o = 1'b0,
  // Bench control
  input  wire       go_i,
  input  wire [4:0] len_i,
  output reg        busy_o = 1'b0,
  output reg  [3:0] rx_last_o = 4'h0,
  output reg  [7:0] rx_count_o = 8'h0
);
  reg [4:0] idx = 5'h0;
  // Launch after a rise so the nibble stands over the next rise
  always @(posedge wan_tx_clock_i)
    if (busy_o && idx != len_i)
    begin
      wan_tx_nibble_o <= idx[3:0] ^ 4'ha;
      wan_tx_enable_o <= 1'b1;
      idx <= idx + 5'h1;
    end
    else
    begin
      wan_tx_nibble_o <= ~wan_tx_nibble_o;
      wan_tx_enable_o <= 1'b0;
      idx <= 5'h0;
      busy_o <= go_i && !busy_o;
    end
  always @(posedge wan_rx_clock_i)
    if (wan_rx_valid_i)
    begin
      rx_last_o <= wan_rx_nibble_i;
      rx_count_o <= rx_count_o + 8'h1;
    end
endmodule // wan_mac_model

// >>> tb/wan_port_bench.sv
// Bench top for the WAN port block: straps, bus, nibble traffic both ways.
// Assumes the MAC model and the checker are compiled before this file.
`timescale 1ns/100ps
module wan_port_bench;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc_i = 1'b0;
  reg         stb_i = 1'b0;
  reg         we_i = 1'b0;
  reg  [3:0]  adr_i = 4'h0;
  reg  [31:0] dat_i = 32'h0;
  wire [3:0]  sel_i = 4'hf;
  wire [31:0] dat_o;
  wire        ack_o;
  // Straps {role, select, duplex, speed, alternate force, force}
  reg  [21:0] st = 22'h0;
  wire [4:0]  force_strap_i = st[4:0];
  wire [4:0]  force_alt_strap_i = st[9:5];
  wire [4:0]  speed_strap_i = st[14:10];
  wire [4:0]  duplex_strap_i = st[19:15];
  wire        external_port_select_strap_i = st[20];
  wire        lan_if_mac_role_strap_i = st[21];
  wire [4:0]  autonegotiation_o, forced_100_o, forced_full_o;
  wire        lan_phy_forced_o, lan_phy_100_o, lan_phy_full_o, lan_mac_role_o;
  wire        wan_tx_clock_o, wan_rx_clock_o, wan_tx_enable_i, wan_rx_valid_o;
  wire        wan_collision_o, sw_rx_sof_o, sw_rx_valid_o, sw_tx_ready_o, busy;
  wire [3:0]  wan_tx_nibble_i, wan_rx_nibble_o, sw_rx_nibble_o, rx_last;
  wire [7:0]  rx_count;
  reg         sw_rx_ready_i = 1'b1;
  reg  [3:0]  sw_tx_nibble_i = 4'h0;
  reg         sw_tx_valid_i = 1'b0;
  reg         sw_collision_i = 1'b0;
  reg         go = 1'b0;
  reg  [4:0]  len = 5'h0;
  reg  [4:0]  got[$];
  reg  [31:0] q;
  integer     n_mismatch = 0;
  integer     check_count = 0;

  wan_port u_wan_port (
    .clk_i                        (clk_i),
    .rst_i                        (rst_i),
    .cyc_i                        (cyc_i),
    .stb_i                        (stb_i),
    .we_i                         (we_i),
    .adr_i                        (adr_i),
    .sel_i                        (sel_i),
    .dat_i                        (dat_i),
    .dat_o                        (dat_o),
    .ack_o                        (ack_o),
    .force_strap_i                (force_strap_i),
    .force_alt_strap_i            (force_alt_strap_i),
    .speed_strap_i                (speed_strap_i),
    .duplex_strap_i               (duplex_strap_i),
    .external_port_select_strap_i (external_port_select_strap_i),
    .lan_if_mac_role_strap_i      (lan_if_mac_role_strap_i),
    .autonegotiation_o            (autonegotiation_o),
    .forced_100_o                 (forced_100_o),
    .forced_full_o                (forced_full_o),
    .lan_phy_forced_o             (lan_phy_forced_o),
    .lan_phy_100_o                (lan_phy_100_o),
    .lan_phy_full_o               (lan_phy_full_o),
    .lan_mac_role_o               (lan_mac_role_o),
    .wan_tx_clock_o               (wan_tx_clock_o),
    .wan_rx_clock_o               (wan_rx_clock_o),
    .wan_tx_nibble_i              (wan_tx_nibble_i),
    .wan_tx_enable_i              (wan_tx_enable_i),
    .wan_rx_nibble_o              (wan_rx_nibble_o),
    .wan_rx_valid_o               (wan_rx_valid_o),
    .wan_collision_o              (wan_collision_o),
    .sw_rx_nibble_o               (sw_rx_nibble_o),
    .sw_rx_sof_o                  (sw_rx_sof_o),
    .sw_rx_valid_o                (sw_rx_valid_o),
    .sw_rx_ready_i                (sw_rx_ready_i),
    .sw_tx_nibble_i               (sw_tx_nibble_i),
    .sw_tx_valid_i                (sw_tx_valid_i),
    .sw_tx_ready_o                (sw_tx_ready_o),
    .sw_collision_i               (sw_collision_i)
  );
  wan_mac_model u_wan_mac_model (
    .wan_tx_clock_i  (wan_tx_clock_o),
    .wan_rx_clock_i  (wan_rx_clock_o),
    .wan_rx_nibble_i (wan_rx_nibble_o),
    .wan_rx_valid_i  (wan_rx_valid_o),
    .wan_tx_nibble_o (wan_tx_nibble_i),
    .wan_tx_enable_o (wan_tx_enable_i),
    .go_i            (go),
    .len_i           (len),
    .busy_o          (busy),
    .rx_last_o       (rx_last),
    .rx_count_o      (rx_count)
  );

  always #10 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (sw_rx_valid_o && sw_rx_ready_i)
      got.push_back({sw_rx_sof_o, sw_rx_nibble_o});

  task check(input [31:0] seen, input [31:0] want);
    check_count = check_count + 1;
    if (seen !== want)
    begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task wb(input w, input [3:0] a, input [31:0] d, output [31:0] r);
    integer k;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    for (k = 0; k < 50 && ack_o !== 1'b1; k = k + 1)
      @(posedge clk_i);
    check(ack_o, 32'h1);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Frame from the MAC; k nibbles must reach the switch side
  task frame_in(input [4:0] n, input [31:0] k);
    integer i;
    got.delete();
    go <= 1'b1;
    len <= n;
    repeat (200) if (busy !== 1'b1) @(posedge clk_i);
    go <= 1'b0;
    repeat (800) if (busy !== 1'b0) @(posedge clk_i);
    repeat (20) @(posedge clk_i);
    sw_rx_ready_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    check(got.size(), k);
    for (i = 0; i < got.size(); i = i + 1)
      check(got[i], {i == 0, i[3:0] ^ 4'ha});
  endtask

  task frame_out(input [4:0] n);
    integer i;
    reg [7:0] c0;
    c0 = rx_count;
    for (i = 0; i < n; i = i + 1)
    begin
      sw_tx_nibble_i <= i[3:0] ^ 4'h5;
      sw_tx_valid_i <= 1'b1;
      @(posedge clk_i);
      repeat (100) if (sw_tx_ready_o !== 1'b1) @(posedge clk_i);
    end
    sw_tx_valid_i <= 1'b0;
    repeat (60) @(posedge clk_i);
    check(rx_count - c0, n);
    check(rx_last, (n[3:0] - 4'h1) ^ 4'h5);
  endtask

  task run_cfg(input [21:0] c);
    reg [4:0] f;
    reg       e;
    st <= c;
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    st <= ~c;
    @(posedge clk_i);
    f = c[21] ? c[9:5] : c[4:0];
    e = c[20] & !c[21] & f[4];
    check(autonegotiation_o, f ^ 5'h1f);
    check(forced_100_o & f, c[14:10] & f);
    check(forced_full_o & f, c[19:15] & f);
    check({lan_mac_role_o, lan_phy_forced_o}, {c[21], e});
    check({lan_phy_100_o, lan_phy_full_o} & {2{e}}, {c[14], c[19]} & {2{e}});
    wb(1'b0, 4'h4, 32'h0, q);
    check(q, {15'h0, c[21:10], f});
    frame_in(5'h06, 6);
    frame_out(5'h04);
    sw_collision_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    check(wan_collision_o, f[4] & !c[19]);
    sw_collision_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b1, 4'h0, 32'h3, q);
    repeat (3) @(posedge clk_i);
    check(wan_collision_o, f[4] & !c[19]);
    wb(1'b1, 4'h0, 32'h1, q);
    $display("strap set %h done", c);
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    run_cfg(22'h0);
    run_cfg({1'h0, 1'h1, 5'h0a, 5'h15, 5'h00, 5'h1f});
    run_cfg({1'h1, 1'h1, 5'h1f, 5'h00, 5'h10, 5'h0f});
    wb(1'b1, 4'h2, 32'hffffffff, q);
    wb(1'b0, 4'h2, 32'h0, q);
    check(q, 32'h0);
    wb(1'b0, 4'h0, 32'h0, q);
    check(q, 32'h1);
    wb(1'b0, 4'hc, 32'h0, q);
    check(q, 32'h1);
    wb(1'b1, 4'h0, 32'h0, q);
    frame_in(5'h04, 0);
    wb(1'b1, 4'h0, 32'h1, q);
    sw_rx_ready_i <= 1'b0;
    frame_in(5'h06, 3);
    $display("register and buffer tests done");
    tally_and_finish;
  end

  initial
  begin
    #500000;
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
endmodule // wan_port_bench

bind wan_port wan_port_assertions #(.NPORTS(NPORTS)) u_wan_port_assertions (
  .clk_i             (clk_i),
  .rst_i             (rst_i),
  .cyc_i             (cyc_i),
  .stb_i             (stb_i),
  .ack_o             (ack_o),
  .autonegotiation_o (autonegotiation_o),
  .forced_100_o      (forced_100_o),
  .forced_full_o     (forced_full_o),
  .lan_phy_forced_o  (lan_phy_forced_o),
  .lan_mac_role_o    (lan_mac_role_o),
  .wan_tx_clock_o    (wan_tx_clock_o),
  .wan_rx_clock_o    (wan_rx_clock_o),
  .wan_rx_nibble_o   (wan_rx_nibble_o),
  .wan_rx_valid_o    (wan_rx_valid_o),
  .wan_collision_o   (wan_collision_o),
  .sw_collision_i    (sw_collision_i)
);
